/* File: src/bor_pkg.sv */
// bor_pkg: constants and carriers for the bus options register block
// assumes a single 250 MHz clock domain and an apb register port
`default_nettype none
package bor_pkg;
    // register byte offset
    localparam logic [7:0]  BOR_OFF_OPTIONS   = 8'h20;
    // bus info block address seen by remote nodes (second quadlet)
    localparam logic [47:0] BOR_REMOTE_ADDR   = 48'hffff_f000_0408;
    // field positions
    localparam int          BOR_CAP_HI        = 31;
    localparam int          BOR_CAP_LO        = 27;
    localparam int          BOR_ACC_HI        = 23;
    localparam int          BOR_ACC_LO        = 16;
    localparam int          BOR_PAY_HI        = 15;
    localparam int          BOR_PAY_LO        = 12;
    localparam int          BOR_GEN_HI        = 7;
    localparam int          BOR_GEN_LO        = 6;
    localparam int          BOR_SPD_HI        = 2;
    localparam int          BOR_SPD_LO        = 0;
    // reset and fixed values
    localparam logic [31:0] BOR_RESET_VALUE   = 32'h0000_a002;
    localparam logic [3:0]  BOR_PAY_RESET     = 4'ha;       // 2048 bytes
    localparam logic [2:0]  BOR_LINK_SPEED    = 3'h2;       // 100/200/400
    localparam logic [31:0] BOR_WRITE_MASK    = 32'hf8ff_f0c0;

    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } bor_apb_req_s;

    // apb answer carrier
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } bor_apb_rsp_s;

    // remote quadlet read carrier
    typedef struct packed {
        logic        valid;
        logic [47:0] addr;
    } bor_rq_s;

    // byte limit from payload code: 2^(code+1); shift kept 5 bits so code 15 gives 64 KiB
    function automatic logic [16:0] bor_max_bytes(input logic [3:0] code);
        bor_max_bytes = 17'h0_0001 << ({1'b0, code} + 5'h01);
    endfunction
endpackage
`default_nettype wire

/* File: src/bor_len_check.sv */
// bor_len_check: flags a received block write longer than the payload limit
// assumes length and strobe come from logic on the same clock
`default_nettype none
module bor_len_check
    import bor_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [3:0]  pay_code,
    input  wire logic        blk_wr_valid,
    input  wire logic [15:0] blk_wr_len,
    output var  logic        ack_type_error
);
    typedef struct packed {
        logic err;
    } bor_chk_s;

    bor_chk_s st_q;
    bor_chk_s st_d;

    // compare length with the limit each offered block write
    always_comb begin
        st_d     = st_q;
        st_d.err = blk_wr_valid && ({1'b0, blk_wr_len} > bor_max_bytes(pay_code));
    end

    // register the verdict
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ack_type_error = st_q.err;

    a_len_err_flag : assert property (@(posedge clock) disable iff (srst)
        blk_wr_valid && ({1'b0, blk_wr_len} > bor_max_bytes(pay_code)) |=> ack_type_error)
        else $error("oversized block write not flagged");
endmodule
`default_nettype wire

/* File: src/bor_top.sv */
// bor_top: bus options register with apb access and remote quadlet reads
// assumes one clock; hard_rst reloads everything, srst is the soft reset
//
// Added by the designer: the APB register port.
`default_nettype none
module bor_top
    import bor_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  hard_rst,
    input  wire bor_pkg::bor_apb_req_s apb_req,
    output var  bor_pkg::bor_apb_rsp_s apb_rsp,
    input  wire bor_pkg::bor_rq_s      remote_rd,
    output var  logic                  remote_rd_valid,
    output var  logic [31:0]           remote_rd_data,
    input  wire logic                  blk_wr_valid,
    input  wire logic [15:0]           blk_wr_len,
    output var  logic                  ack_type_error,
    output var  logic [3:0]            pay_code
);
    import bor_pkg::*;

    typedef struct packed {
        logic [4:0]   cap;
        logic [7:0]   acc;
        logic [3:0]   pay;
        logic [1:0]   gen;
        bor_apb_rsp_s rsp;
        logic         rr_valid;
        logic [31:0]  rr_data;
    } bor_state_s;

    bor_state_s st_q;
    bor_state_s st_d;
    logic       wr_hit;
    logic [31:0] reg_view;

    // assemble the readable word; reserved bits are zero
    always_comb begin
        reg_view = '0;
        reg_view[BOR_CAP_HI:BOR_CAP_LO] = st_q.cap;
        reg_view[BOR_ACC_HI:BOR_ACC_LO] = st_q.acc;
        reg_view[BOR_PAY_HI:BOR_PAY_LO] = st_q.pay;
        reg_view[BOR_GEN_HI:BOR_GEN_LO] = st_q.gen;
        reg_view[BOR_SPD_HI:BOR_SPD_LO] = BOR_LINK_SPEED;
    end

    // apb access phase: one wait state, answer registered
    assign wr_hit = apb_req.psel && apb_req.penable && apb_req.pwrite
                    && !st_q.rsp.pready && (apb_req.paddr == BOR_OFF_OPTIONS);

    // next state
    always_comb begin
        st_d            = st_q;
        st_d.rsp        = '0;
        st_d.rr_valid   = 1'b0;
        if (apb_req.psel && apb_req.penable && !st_q.rsp.pready) begin
            st_d.rsp.pready = 1'b1;
            if (apb_req.paddr != BOR_OFF_OPTIONS) begin
                st_d.rsp.pslverr = 1'b1;                          // unmapped address
            end else if (!apb_req.pwrite) begin
                st_d.rsp.prdata = reg_view;
            end
        end
        if (wr_hit) begin
            st_d.cap = apb_req.pwdata[BOR_CAP_HI:BOR_CAP_LO];
            st_d.acc = apb_req.pwdata[BOR_ACC_HI:BOR_ACC_LO];
            st_d.pay = apb_req.pwdata[BOR_PAY_HI:BOR_PAY_LO];
            st_d.gen = apb_req.pwdata[BOR_GEN_HI:BOR_GEN_LO];
        end
        // remote quadlet read of the bus info block
        if (remote_rd.valid && remote_rd.addr == BOR_REMOTE_ADDR) begin
            st_d.rr_valid = 1'b1;
            st_d.rr_data  = reg_view;
        end
    end

    // registers; hard reset loads the defaults, soft reset keeps the payload code and lets cap, acc and gen take a write in the same cycle
    always_ff @(posedge clock) begin
        if (hard_rst) begin
            st_q     <= '0;
            st_q.pay <= BOR_PAY_RESET;
        end else if (srst) begin
            st_q     <= '0;
            st_q.cap <= st_d.cap;
            st_q.acc <= st_d.acc;
            st_q.gen <= st_d.gen;
            st_q.pay <= st_q.pay;
        end else begin
            st_q <= st_d;
        end
    end

    // oversized block write checker
    bor_len_check u_len_check (
        .clock          (clock),
        .srst           (srst | hard_rst),
        .pay_code       (st_q.pay),
        .blk_wr_valid   (blk_wr_valid),
        .blk_wr_len     (blk_wr_len),
        .ack_type_error (ack_type_error)
    );

    // outputs straight from flip-flops
    assign apb_rsp         = st_q.rsp;
    assign remote_rd_valid = st_q.rr_valid;
    assign remote_rd_data  = st_q.rr_data;
    assign pay_code        = st_q.pay;

    a_remote_rd_data : assert property (@(posedge clock) disable iff (srst || hard_rst)
        remote_rd.valid && remote_rd.addr == BOR_REMOTE_ADDR |=> remote_rd_valid
        && remote_rd_data == $past(reg_view))
        else $error("remote read answer wrong");
    a_cap_write : assert property (@(posedge clock) disable iff (srst || hard_rst)
        wr_hit |=> reg_view[31:27] == $past(apb_req.pwdata[31:27]))
        else $error("capability flags not written");
    a_acc_write : assert property (@(posedge clock) disable iff (srst || hard_rst)
        wr_hit |=> reg_view[23:16] == $past(apb_req.pwdata[23:16]))
        else $error("accuracy not written");
    a_pay_write : assert property (@(posedge clock) disable iff (srst || hard_rst)
        wr_hit |=> pay_code == $past(apb_req.pwdata[15:12]))
        else $error("payload code not written");
    a_pay_hard_rst : assert property (@(posedge clock)
        hard_rst |=> pay_code == 4'ha)
        else $error("payload code not loaded by hard reset");
    a_pay_soft_keep : assert property (@(posedge clock) disable iff (hard_rst)
        srst |=> $stable(pay_code))
        else $error("soft reset changed payload code");
    a_speed_const : assert property (@(posedge clock)
        reg_view[2:0] == 3'b010)
        else $error("link speed field wrong");
    a_reserved_zero : assert property (@(posedge clock) disable iff (srst || hard_rst)
        apb_rsp.pready && !apb_rsp.pslverr |-> (apb_rsp.prdata & 32'h0700_0f38) == '0)
        else $error("reserved bits not zero");
    a_gen_wrap : assert property (@(posedge clock) disable iff (srst || hard_rst)
        wr_hit && reg_view[7:6] == 2'd3 && apb_req.pwdata[7:6] == 2'd0
        |=> reg_view[7:6] == 2'd0)
        else $error("generation counter did not wrap");
endmodule
`default_nettype wire

/* File: sim/bor_remote_node.sv */
// bor_remote_node: far 1394 node that reads bus info quadlets
// assumes the block samples rd_req on the rising clock edge
`default_nettype none
module bor_remote_node
    import bor_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rd_valid,
    input  wire logic [31:0]      rd_data,
    output var  bor_pkg::bor_rq_s rd_req
);
    initial rd_req = '0;
    // one quadlet read; got stays low when nothing answers in 4 cycles
    task automatic read_quadlet(input logic [47:0] addr, output logic [31:0] data,
                                output logic got);
        got = 1'b0;
        data = 32'h0000_0000;
        rd_req <= '{valid: 1'b1, addr: addr};
        @(posedge clock);
        rd_req <= '{valid: 1'b0, addr: ~addr};  // released address does not stay stale
        repeat (4) begin
            @(posedge clock);
            if (rd_valid === 1'b1) begin
                got = 1'b1;
                data = rd_data;
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: sim/test_bus_options_register.sv */
// test_bus_options_register: self-checking bench for bor_top
// assumes the bor_remote_node model stands on the remote read port
`default_nettype none
module test_bus_options_register
    import bor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, srst = 1, hard_rst = 1, got, err, blk_wr_valid = 0;
    logic ack_type_error, remote_rd_valid;
    logic [15:0] blk_wr_len = 16'h0000;
    logic [31:0] remote_rd_data, rd;
    logic [3:0] pay_code;
    bor_apb_req_s apb_req = '0;
    bor_apb_rsp_s apb_rsp;
    bor_rq_s remote_rd;
    int bad_count = 0, num_checks = 0;
    bor_top dut (.clock(clock), .srst(srst), .hard_rst(hard_rst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .remote_rd(remote_rd), .remote_rd_valid(remote_rd_valid),
        .remote_rd_data(remote_rd_data), .blk_wr_valid(blk_wr_valid),
        .blk_wr_len(blk_wr_len), .ack_type_error(ack_type_error), .pay_code(pay_code));
    bor_remote_node node (.clock(clock), .rd_valid(remote_rd_valid),
        .rd_data(remote_rd_data), .rd_req(remote_rd));
    // 250 MHz clock
    always #2 clock = ~clock;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (apb_rsp.pready !== 1'b1) begin
            bad_count++;
            $display("MISMATCH at %0t: no apb answer", $time);
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge clock);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    // offered block write; ack seen over the two following cycles
    task automatic blk(input logic [15:0] len, input logic exp);
        logic a;
        blk_wr_valid <= 1'b1;
        blk_wr_len <= len;
        @(posedge clock);
        blk_wr_valid <= 1'b0;
        @(posedge clock);
        a = ack_type_error;
        @(posedge clock);
        a = a | ack_type_error;
        check({31'h0, a}, {31'h0, exp});
    endtask
    task automatic t_fields();
        apb(1'b1, BOR_OFF_OPTIONS, 32'hffff_ffff);
        rdchk(BOR_OFF_OPTIONS, 32'hf8ff_f0c2);
        node.read_quadlet(BOR_REMOTE_ADDR, rd, got);
        check(rd, 32'hf8ff_f0c2);
        node.read_quadlet(48'hffff_f000_040c, rd, got);
        check({31'h0, got}, 32'h0000_0000);
        apb(1'b1, BOR_OFF_OPTIONS, 32'h0000_80c0);
        rdchk(BOR_OFF_OPTIONS, 32'h0000_80c2);
        apb(1'b1, BOR_OFF_OPTIONS, 32'h0000_8000);
        rdchk(BOR_OFF_OPTIONS, 32'h0000_8002);
        $display("done fields");
    endtask
    task automatic t_unmapped();
        apb(1'b1, 8'h24, 32'hffff_ffff);
        check({31'h0, err}, 32'h0000_0001);
        rdchk(8'h24, 32'h0000_0000);
        rdchk(BOR_OFF_OPTIONS, 32'h0000_8002);
        $display("done unmapped");
    endtask
    // payload limits for 512 and 1024 bytes, both sides of each
    task automatic t_len();
        for (int c = 8; c < 10; c++) begin
            apb(1'b1, BOR_OFF_OPTIONS, {16'h0000, c[3:0], 12'h000});
            blk(16'(2 << c), 1'b0);
            blk(16'((2 << c) + 1), 1'b1);
        end
        $display("done length");
    endtask
    task automatic t_resets();
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        rdchk(BOR_OFF_OPTIONS, 32'h0000_9002);
        hard_rst <= 1'b1;
        @(posedge clock);
        hard_rst <= 1'b0;
        @(posedge clock);
        check({28'h0, pay_code}, 32'h0000_000a);
        rdchk(BOR_OFF_OPTIONS, BOR_RESET_VALUE);
        $display("done resets");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence after a 4 cycle reset
    initial begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        hard_rst <= 1'b0;
        @(posedge clock);
        rdchk(BOR_OFF_OPTIONS, BOR_RESET_VALUE);
        t_fields();
        t_unmapped();
        t_len();
        t_resets();
        finish_test();
    end
    // watchdog well beyond the expected run
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire
